/* hdl/glb_regs.sv */
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "glb_map.svh"

// Overview of operation
// RL1 - noise gate alignment active when bit set
// RL2 - bit selects tone generator clock source
// RL3 - combine attenuation by sum or maximum
// RL4 - five-bit tone generator signal select
// RL5 - volume half-dB steps, mute above C8h
// RL6 - limiter dynamic headroom enable, resets on
// RL7 - four-bit limiter attack rate field
// RL8 - limiter enable bit, resets off
// RL9 - limiter pauses during brownout when set
// RL10 - four-bit limiter release rate field
// RL11 - limiter hold code maps to milliseconds
// RL12 - five-bit limiter maximum headroom field
// RL13 - level zero: attenuate or mute+shutdown
// RL14 - brownout prevention enable, resets off
// RL15 - hold release self-clearing, zero ignored
// RL16 - combined attenuation capped by maximum
// RL17 - level three dwell code maps to us
// RL18 - four-bit level three attack step
// RL19 - alignment refined by noise gate option
// RL20 - reserved bits read zero, ignore writes
// RL21 - software avoids reserved field codes
module glb_regs (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [9:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic noise_gate_active,
	input wire logic brownout_active,
	input wire logic brownout_level0_reached,
	input wire glb_pkg::glb_atten_t limiter_atten,
	input wire glb_pkg::glb_atten_t brownout_atten,
	output logic noise_gate_align_active,
	output logic tone_gen_clock_select,
	output logic attenuation_combine_select,
	output logic [4:0] tone_gen_signal_select,
	output logic [7:0] volume_level,
	output logic volume_mute,
	output logic limiter_dynamic_headroom_enable,
	output logic [3:0] limiter_attack_rate,
	output logic limiter_run,
	output logic [3:0] limiter_release_rate,
	output glb_pkg::glb_ms_t limiter_hold_ms,
	output logic [4:0] limiter_max_headroom,
	output logic brownout_prevention_enable,
	output logic brownout_level0_attenuate,
	output logic brownout_level0_shutdown,
	output logic brownout_hold_release,
	output glb_pkg::glb_atten_t combined_atten,
	output glb_pkg::glb_us_t brownout_l3_dwell_us,
	output logic [3:0] brownout_l3_attack_step
);
	import glb_pkg::*;

	// ************************************************************
	// apb decode
	// ************************************************************
	logic pready_r; // one wait state, then ready
	glb_byte_t rdata_r; // read byte, upper bits zero
	logic pslverr_r; // unmapped or misaligned
	wire access_w = psel & penable; // access phase
	wire first_w = access_w & ~pready_r; // first access cycle
	wire done_w = access_w & pready_r; // completing edge
	wire wr_w = done_w & pwrite; // write takes effect
	wire [7:0] idx_w = paddr[9:2]; // register index
	wire align_w = (paddr[1:0] == 2'b00); // word aligned
	wire hit_diag = align_w & (idx_w == `GLB_IDX_DIAG);
	wire hit_vol = align_w & (idx_w == `GLB_IDX_VOL);
	wire hit_lima = align_w & (idx_w == `GLB_IDX_LIMA);
	wire hit_limb = align_w & (idx_w == `GLB_IDX_LIMB);
	wire hit_bopa = align_w & (idx_w == `GLB_IDX_BOPA);
	wire hit_bopb = align_w & (idx_w == `GLB_IDX_BOPB);
	wire hit_bopc = align_w & (idx_w == `GLB_IDX_BOPC);
	wire hit_any = hit_diag | hit_vol | hit_lima | hit_limb |
		hit_bopa | hit_bopb | hit_bopc;

	// ************************************************************
	// register storage
	// ************************************************************
	glb_byte_t diag_q; // tone generator, combine mode and noise gate alignment
	glb_byte_t vol_q; // digital volume
	glb_byte_t lima_q; // limiter config a
	glb_byte_t limb_q; // limiter config b
	glb_byte_t bopa_q; // brownout config a
	glb_byte_t bopb_q; // brownout config b
	glb_byte_t bopc_q; // brownout config c
	wire glb_byte_t wbyte_w = pwdata[7:0]; // upper lanes unused

	// masks keep reserved bits at zero RL20
	glb_cfg_reg #(.RESET(`GLB_RST_DIAG), .WMASK(`GLB_WM_FULL))
	u_diag (
		.pclk(pclk), .presetn(presetn),
		.we(wr_w & hit_diag), .wdata(wbyte_w), .q(diag_q)
	);
	glb_cfg_reg #(.RESET(`GLB_RST_VOL), .WMASK(`GLB_WM_FULL))
	u_vol (
		.pclk(pclk), .presetn(presetn),
		.we(wr_w & hit_vol), .wdata(wbyte_w), .q(vol_q)
	);
	glb_cfg_reg #(.RESET(`GLB_RST_LIMA), .WMASK(`GLB_WM_LIMA))
	u_lima (
		.pclk(pclk), .presetn(presetn),
		.we(wr_w & hit_lima), .wdata(wbyte_w), .q(lima_q)
	);
	glb_cfg_reg #(.RESET(`GLB_RST_LIMB), .WMASK(`GLB_WM_FULL))
	u_limb (
		.pclk(pclk), .presetn(presetn),
		.we(wr_w & hit_limb), .wdata(wbyte_w), .q(limb_q)
	);
	glb_cfg_reg #(.RESET(`GLB_RST_BOPA), .WMASK(`GLB_WM_BOPA))
	u_bopa (
		.pclk(pclk), .presetn(presetn),
		.we(wr_w & hit_bopa), .wdata(wbyte_w), .q(bopa_q)
	);
	// release bit is not stored: it only fires a pulse
	glb_cfg_reg #(.RESET(`GLB_RST_BOPB), .WMASK(`GLB_WM_BOPB))
	u_bopb (
		.pclk(pclk), .presetn(presetn),
		.we(wr_w & hit_bopb), .wdata(wbyte_w), .q(bopb_q)
	);
	glb_cfg_reg #(.RESET(`GLB_RST_BOPC), .WMASK(`GLB_WM_BOPC))
	u_bopc (
		.pclk(pclk), .presetn(presetn),
		.we(wr_w & hit_bopc), .wdata(wbyte_w), .q(bopc_q)
	);

	// ************************************************************
	// read mux and apb answer
	// ************************************************************
	glb_byte_t rsel_w; // selected register
	assign rsel_w = hit_diag ? diag_q :
		hit_vol ? vol_q :
		hit_lima ? lima_q :
		hit_limb ? limb_q :
		hit_bopa ? bopa_q :
		hit_bopb ? bopb_q :
		hit_bopc ? bopc_q : 8'h00;

	// answer one cycle into the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			rdata_r <= 8'h00;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= first_w;
			rdata_r <= (first_w & ~pwrite) ? rsel_w : 8'h00;
			pslverr_r <= first_w & ~hit_any;
		end
	end
	assign pready = pready_r;
	assign prdata = {24'h000000, rdata_r};
	assign pslverr = pslverr_r;

	// ************************************************************
	// decoded controls
	// ************************************************************
	// plain fields come straight from the register flops
	assign tone_gen_clock_select = diag_q[`GLB_B_TONE_CLK]; // RL2
	assign attenuation_combine_select = diag_q[`GLB_B_COMBINE]; // RL3
	assign tone_gen_signal_select = diag_q[`GLB_F_TONE_SIG]; // RL4
	assign volume_level = vol_q; // RL5
	assign limiter_dynamic_headroom_enable = lima_q[`GLB_B_DHR_EN]; // RL6
	assign limiter_attack_rate = lima_q[`GLB_F_ATK_RT]; // RL7
	assign limiter_release_rate = limb_q[`GLB_F_RLS_RT]; // RL10
	assign limiter_max_headroom = bopa_q[`GLB_F_HEADROOM]; // RL12
	assign brownout_prevention_enable = bopa_q[`GLB_B_BROWNOUT_PREVENTION_ENABLE]; // RL14
	assign brownout_l3_attack_step = bopc_q[`GLB_F_ATK_ST]; // RL18
	// reserved codes are passed through untouched; software avoids them

	wire limiter_enable_w = lima_q[`GLB_B_LIMITER_ENABLE]; // limiter on
	wire pause_w = limb_q[`GLB_B_PAUSE]; // pause in brownout
	wire brownout_prevention_enable_w = bopa_q[`GLB_B_BROWNOUT_PREVENTION_ENABLE]; // brownout on
	wire shdn_w = bopa_q[`GLB_B_SHDN]; // level 0 action
	wire glb_atten_t cap_w = bopb_q[`GLB_F_MAX_ATT]; // cap
	wire combine_w = diag_q[`GLB_B_COMBINE]; // 1 = max
	wire ng_en_w = diag_q[`GLB_B_NG_ALIGN]; // alignment opt

	// limiter runs when enabled, unless paused by active brownout
	wire lim_run_nxt = limiter_enable_w & ~(pause_w & brownout_active); // RL8 RL9
	// refined alignment only while the gate is closed
	wire ng_nxt = ng_en_w & noise_gate_active; // RL1 RL19
	wire mute_nxt = vol_q > `GLB_VOL_MAX_CODE; // RL5
	wire l0_hit_w = brownout_prevention_enable_w & brownout_level0_reached;
	wire l0_att_nxt = l0_hit_w & ~shdn_w; // RL13
	wire l0_sd_nxt = l0_hit_w & shdn_w; // RL13
	// a write of 1 pulses once, a write of 0 does nothing
	wire rel_nxt = wr_w & hit_bopb & pwdata[`GLB_B_HOLD_CLR]; // RL15

	// ************************************************************
	// attenuation combine and cap
	// ************************************************************
	// idle paths contribute nothing to the total
	wire glb_atten_t lim_part_w = lim_run_nxt ? limiter_atten : 7'h00;
	wire glb_atten_t bop_part_w = brownout_prevention_enable_w ? brownout_atten : 7'h00;
	// eight bits so the sum of two 7-bit values cannot wrap
	wire [7:0] sum_w = {1'b0, lim_part_w} + {1'b0, bop_part_w}; // RL3
	wire [7:0] max_w = (lim_part_w > bop_part_w) ?
		{1'b0, lim_part_w} : {1'b0, bop_part_w}; // RL3
	wire [7:0] pick_w = combine_w ? max_w : sum_w; // RL3
	wire glb_atten_t comb_nxt = (pick_w > {1'b0, cap_w}) ?
		cap_w : pick_w[6:0]; // RL16

	// ************************************************************
	// time lookups
	// ************************************************************
	glb_ms_t hold_nxt; // limiter hold in ms
	glb_us_t dwell_nxt; // level three dwell in us
	// table decode of hold and dwell codes
	always_comb begin
		unique case (limb_q[`GLB_F_HOLD]) // RL11
			3'h0: hold_nxt = `GLB_HOLD_0;
			3'h1: hold_nxt = `GLB_HOLD_1;
			3'h2: hold_nxt = `GLB_HOLD_2;
			3'h3: hold_nxt = `GLB_HOLD_3;
			3'h4: hold_nxt = `GLB_HOLD_4;
			3'h5: hold_nxt = `GLB_HOLD_5;
			3'h6: hold_nxt = `GLB_HOLD_6;
			3'h7: hold_nxt = `GLB_HOLD_7;
		endcase
		unique case (bopc_q[`GLB_F_DWELL]) // RL17
			3'h0: dwell_nxt = `GLB_DWELL_0;
			3'h1: dwell_nxt = `GLB_DWELL_1;
			3'h2: dwell_nxt = `GLB_DWELL_2;
			3'h3: dwell_nxt = `GLB_DWELL_3;
			3'h4: dwell_nxt = `GLB_DWELL_4;
			3'h5: dwell_nxt = `GLB_DWELL_5;
			3'h6: dwell_nxt = `GLB_DWELL_6;
			3'h7: dwell_nxt = `GLB_DWELL_7;
		endcase
	end

	// ************************************************************
	// output flops
	// ************************************************************
	logic ng_r; // alignment refinement active
	logic mute_r; // volume mute
	logic lim_run_r; // limiter running
	logic l0_att_r; // level 0 attenuate
	logic l0_sd_r; // level 0 mute and shutdown
	logic rel_r; // hold release pulse
	glb_atten_t comb_r; // capped total attenuation
	glb_ms_t hold_r; // hold time
	glb_us_t dwell_r; // dwell time
	// all derived outputs registered to keep paths short
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ng_r <= 1'b0;
			mute_r <= 1'b0;
			lim_run_r <= 1'b0;
			l0_att_r <= 1'b0;
			l0_sd_r <= 1'b0;
			rel_r <= 1'b0;
			comb_r <= 7'h00;
			hold_r <= `GLB_HOLD_0;
			dwell_r <= `GLB_DWELL_0;
		end else begin
			ng_r <= ng_nxt;
			mute_r <= mute_nxt;
			lim_run_r <= lim_run_nxt;
			l0_att_r <= l0_att_nxt;
			l0_sd_r <= l0_sd_nxt;
			rel_r <= rel_nxt;
			comb_r <= comb_nxt;
			hold_r <= hold_nxt;
			dwell_r <= dwell_nxt;
		end
	end
	assign noise_gate_align_active = ng_r;
	assign volume_mute = mute_r;
	assign limiter_run = lim_run_r;
	assign brownout_level0_attenuate = l0_att_r;
	assign brownout_level0_shutdown = l0_sd_r;
	assign brownout_hold_release = rel_r;
	assign combined_atten = comb_r;
	assign limiter_hold_ms = hold_r;
	assign brownout_l3_dwell_us = dwell_r;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_apb_one_wait: assert property (
		first_w |=> pready ##1 !pready)
		else $error("pready not one cycle after access");
	a_ng_align_follow: assert property ( // RL1
		ng_en_w && noise_gate_active |=> noise_gate_align_active)
		else $error("noise gate alignment not active");
	a_combine_select: assert property ( // RL3
		!combine_w && sum_w <= {1'b0, cap_w}
		|=> combined_atten == $past(sum_w[6:0]))
		else $error("sum mode total wrong");
	a_volume_mute: assert property ( // RL5
		##1 volume_mute == ($past(vol_q) > `GLB_VOL_MAX_CODE))
		else $error("volume mute mismatch");
	a_limiter_pause: assert property ( // RL9
		pause_w && brownout_active |=> !limiter_run)
		else $error("limiter ran during brownout pause");
	a_level0_action: assert property ( // RL13
		l0_hit_w |=> (brownout_level0_shutdown ^
		brownout_level0_attenuate) &&
		brownout_level0_shutdown == $past(shdn_w))
		else $error("level zero action wrong");
	a_hold_release: assert property ( // RL15
		brownout_hold_release |-> $past(wr_w && hit_bopb)
		##1 !brownout_hold_release && !bopb_q[`GLB_B_HOLD_CLR])
		else $error("hold release not a single pulse");
	a_atten_cap: assert property ( // RL16
		##1 combined_atten <= $past(cap_w))
		else $error("combined attenuation above cap");
	a_reserved_zero: assert property ( // RL20
		pready && $past(hit_lima && !pwrite)
		|-> prdata[31:6] == 26'h0000000)
		else $error("reserved bits read nonzero");
	a_limiter_runs: assert property ( // RL8
		limiter_enable_w && !pause_w |=> limiter_run)
		else $error("limiter not running when enabled");
	a_max_select: assert property ( // RL3
		combine_w && max_w <= {1'b0, cap_w}
		|=> combined_atten == $past(max_w[6:0]))
		else $error("max mode total wrong");
	a_level0_gated: assert property ( // RL14
		!brownout_prevention_enable_w |=> !brownout_level0_attenuate &&
		!brownout_level0_shutdown)
		else $error("level zero action while disabled");
	a_refuse_unmapped: assert property (
		first_w && !hit_any |=> pready && pslverr &&
		prdata == 32'h00000000)
		else $error("refused access not flagged");
	a_release_write: assert property ( // RL15
		wr_w && hit_bopb && pwdata[`GLB_B_HOLD_CLR] |=> brownout_hold_release)
		else $error("hold release pulse missing");
endmodule
`default_nettype wire

/* hdl/glb_map.svh */
`ifndef GLB_MAP_SVH
`define GLB_MAP_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define GLB_IDX_DIAG 8'h19
`define GLB_IDX_VOL 8'h1a
`define GLB_IDX_LIMA 8'h1b
`define GLB_IDX_LIMB 8'h1c
`define GLB_IDX_BOPA 8'h1d
`define GLB_IDX_BOPB 8'h1e
`define GLB_IDX_BOPC 8'h1f

// ************************************************************
// reset values and writable-bit masks
// ************************************************************
`define GLB_RST_DIAG 8'h0d
`define GLB_RST_VOL 8'h00
`define GLB_RST_LIMA 8'h22
`define GLB_RST_LIMB 8'h32
`define GLB_RST_BOPA 8'h40
`define GLB_RST_BOPB 8'h32
`define GLB_RST_BOPC 8'h02
`define GLB_WM_FULL 8'hff
`define GLB_WM_LIMA 8'h3f
`define GLB_WM_BOPA 8'hfb
`define GLB_WM_BOPB 8'h7f
`define GLB_WM_BOPC 8'hfe

// ************************************************************
// field positions
// ************************************************************
`define GLB_B_NG_ALIGN 7
`define GLB_B_TONE_CLK 6
`define GLB_B_COMBINE 5
`define GLB_F_TONE_SIG 4:0
`define GLB_B_DHR_EN 5
`define GLB_F_ATK_RT 4:1
`define GLB_B_LIMITER_ENABLE 0
`define GLB_B_PAUSE 7
`define GLB_F_RLS_RT 6:3
`define GLB_F_HOLD 2:0
`define GLB_F_HEADROOM 7:3
`define GLB_B_SHDN 1
`define GLB_B_BROWNOUT_PREVENTION_ENABLE 0
`define GLB_B_HOLD_CLR 7
`define GLB_F_MAX_ATT 6:0
`define GLB_F_DWELL 7:5
`define GLB_F_ATK_ST 4:1

// ************************************************************
// decode constants
// ************************************************************
`define GLB_VOL_MAX_CODE 8'hc8
`define GLB_HOLD_0 11'h000
`define GLB_HOLD_1 11'h00a
`define GLB_HOLD_2 11'h019
`define GLB_HOLD_3 11'h032
`define GLB_HOLD_4 11'h064
`define GLB_HOLD_5 11'h0fa
`define GLB_HOLD_6 11'h1f4
`define GLB_HOLD_7 11'h3e8
`define GLB_DWELL_0 14'h0000
`define GLB_DWELL_1 14'h0064
`define GLB_DWELL_2 14'h00fa
`define GLB_DWELL_3 14'h01f4
`define GLB_DWELL_4 14'h03e8
`define GLB_DWELL_5 14'h07d0
`define GLB_DWELL_6 14'h0fa0
`define GLB_DWELL_7 14'h1f40

`endif

/* hdl/glb_pkg.sv */
package glb_pkg;
	// one configuration register
	typedef logic [7:0] glb_byte_t;
	// attenuation in whole dB
	typedef logic [6:0] glb_atten_t;
	// hold time in ms, dwell time in us
	typedef logic [10:0] glb_ms_t;
	typedef logic [13:0] glb_us_t;
endpackage

/* hdl/glb_cfg_reg.sv */
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// one 8-bit configuration register with writable-bit mask
// ************************************************************
module glb_cfg_reg #(
	parameter glb_pkg::glb_byte_t RESET = 8'h00,
	parameter glb_pkg::glb_byte_t WMASK = 8'hff
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic we,
	input wire glb_pkg::glb_byte_t wdata,
	output glb_pkg::glb_byte_t q
);
	import glb_pkg::*;
	glb_byte_t q_r; // stored value
	glb_byte_t q_nxt; // value after a write
	// masked bits never leave their reset value
	assign q_nxt = (wdata & WMASK) | (RESET & ~WMASK);
	// store on the completing write edge only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_r <= RESET;
		end else if (we) begin
			q_r <= q_nxt;
		end
	end
	assign q = q_r;
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "glb_map.svh"
module tb_top;
	import glb_pkg::*;
	// ************************************************************
	// stimulus and observed signals
	// ************************************************************
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [9:0] paddr = 10'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr;
	logic noise_gate_active = 1'b0, brownout_active = 1'b0;
	logic brownout_level0_reached = 1'b0;
	glb_atten_t limiter_atten = 7'h00, brownout_atten = 7'h00;
	logic noise_gate_align_active, tone_gen_clock_select;
	logic attenuation_combine_select, volume_mute;
	logic [4:0] tone_gen_signal_select, limiter_max_headroom;
	logic [7:0] volume_level;
	logic limiter_dynamic_headroom_enable, limiter_run;
	logic [3:0] limiter_attack_rate, limiter_release_rate;
	logic [3:0] brownout_l3_attack_step;
	glb_ms_t limiter_hold_ms;
	glb_us_t brownout_l3_dwell_us;
	glb_atten_t combined_atten;
	logic brownout_prevention_enable, brownout_level0_attenuate;
	logic brownout_level0_shutdown, brownout_hold_release;
	// bookkeeping
	int failures = 0;
	int tests_run = 0;
	int pulses = 0;
	int p0;
	logic [31:0] rd;
	logic er;
	// expected tables, indexed by register or code
	logic [7:0] idx_tab[7] = '{`GLB_IDX_DIAG, `GLB_IDX_VOL, `GLB_IDX_LIMA,
		`GLB_IDX_LIMB, `GLB_IDX_BOPA, `GLB_IDX_BOPB, `GLB_IDX_BOPC};
	logic [7:0] rst_tab[7] = '{8'h0d, 8'h00, 8'h22, 8'h32, 8'h40, 8'h32, 8'h02};
	// write patterns: every reserved bit set, only legal field codes
	logic [7:0] wp_tab[7] = '{8'hec, 8'hff, 8'hf9, 8'he7, 8'h87, 8'hae, 8'hff};
	logic [7:0] wm_tab[7] = '{8'hec, 8'hff, 8'h39, 8'he7, 8'h83, 8'h2e, 8'hfe};
	int hold_tab[8] = '{0, 10, 25, 50, 100, 250, 500, 1000};
	int dwell_tab[8] = '{0, 100, 250, 500, 1000, 2000, 4000, 8000};
	logic [7:0] vol_tab[4] = '{8'hc8, 8'hc9, 8'h00, 8'h01};

	// 200 mhz clock
	always #2.5 pclk = ~pclk;

	glb_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .prdata, .pslverr, .noise_gate_active,
		.brownout_active, .brownout_level0_reached, .limiter_atten,
		.brownout_atten, .noise_gate_align_active, .tone_gen_clock_select,
		.attenuation_combine_select, .tone_gen_signal_select, .volume_level,
		.volume_mute, .limiter_dynamic_headroom_enable, .limiter_attack_rate,
		.limiter_run, .limiter_release_rate, .limiter_hold_ms,
		.limiter_max_headroom, .brownout_prevention_enable,
		.brownout_level0_attenuate, .brownout_level0_shutdown,
		.brownout_hold_release, .combined_atten, .brownout_l3_dwell_us,
		.brownout_l3_attack_step);

	// counts release pulses; a stuck pulse shows as an extra count
	always @(posedge pclk) begin
		if (brownout_hold_release === 1'b1) begin
			pulses++;
		end
	end

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic check(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h got %h", nm, exp, got);
		end
	endtask

	// one apb transfer; entered just after a rising edge
	task automatic xfer(input logic wr, input logic [9:0] a,
		input logic [7:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		// upper lanes carry junk, they must be ignored
		pwdata <= {24'ha5a5a5, d};
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle count assumed; a hang is left to the watchdog
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		xfer(1'b1, {idx, 2'b00}, d);
	endtask

	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		xfer(1'b0, {idx, 2'b00}, 8'h00);
		check("read data", {24'h0, exp}, rd);
		check("slave error", 32'h0, {31'h0, er});
	endtask

	// derived outputs lag the registers by one cycle
	task automatic settle();
		repeat (3) @(posedge pclk);
	endtask

	task automatic complete_run();
		$display("Checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ************************************************************
	// test sequence
	// ************************************************************
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// reset values and reset state of the outputs
		for (int i = 0; i < 7; i++) begin
			rdc(idx_tab[i], rst_tab[i]);
		end
		check("hold ms", 32'd25, limiter_hold_ms);
		check("headroom en", 32'h1, limiter_dynamic_headroom_enable);
		check("limiter run", 32'h0, limiter_run);
		check("bop enable", 32'h0, brownout_prevention_enable);
		check("tone signal", 32'h0d, tone_gen_signal_select);
		// reserved bits and the release bit read zero
		for (int i = 0; i < 7; i++) begin
			wr(idx_tab[i], wp_tab[i]);
			rdc(idx_tab[i], wm_tab[i]);
		end
		settle();
		check("tone clock", 32'h1, tone_gen_clock_select);
		check("combine sel", 32'h1, attenuation_combine_select);
		check("tone signal", 32'h0c, tone_gen_signal_select);
		check("attack rate", 32'hc, limiter_attack_rate);
		check("max headroom", 32'h10, limiter_max_headroom);
		check("bop enable", 32'h1, brownout_prevention_enable);
		// volume codes either side of the mute boundary
		for (int i = 0; i < 4; i++) begin
			wr(`GLB_IDX_VOL, vol_tab[i]);
			settle();
			check("volume", {24'h0, vol_tab[i]}, volume_level);
			check("mute", {31'h0, vol_tab[i] > 8'hc8}, volume_mute);
		end
		// every hold and dwell code, release codes 1 to 8 and attack step codes 8 to 15
		for (int k = 0; k < 8; k++) begin
			wr(`GLB_IDX_LIMB, {1'b0, 4'(k + 1), 3'(k)});
			wr(`GLB_IDX_BOPC, {3'(k), 4'(15 - k), 1'b0});
			settle();
			check("hold ms", hold_tab[k], limiter_hold_ms);
			check("release", k + 1, limiter_release_rate);
			check("dwell us", dwell_tab[k], brownout_l3_dwell_us);
			check("atk step", 15 - k, brownout_l3_attack_step);
		end
		// limiter enable and pause during brownout
		wr(`GLB_IDX_LIMA, 8'h01);
		wr(`GLB_IDX_LIMB, 8'h88);
		settle();
		check("limiter run", 32'h1, limiter_run);
		check("headroom en", 32'h0, limiter_dynamic_headroom_enable);
		brownout_active <= 1'b1;
		settle();
		check("limiter run", 32'h0, limiter_run);
		wr(`GLB_IDX_LIMB, 8'h08);
		settle();
		check("limiter run", 32'h1, limiter_run);
		wr(`GLB_IDX_LIMA, 8'h00);
		settle();
		check("limiter run", 32'h0, limiter_run);
		brownout_active <= 1'b0;
		// noise gate alignment follows its bit while the gate is held active
		wr(`GLB_IDX_DIAG, 8'h80);
		noise_gate_active <= 1'b1;
		settle();
		check("gate align", 32'h1, noise_gate_align_active);
		wr(`GLB_IDX_DIAG, 8'h00);
		settle();
		check("gate align", 32'h0, noise_gate_align_active);
		check("tone clock", 32'h0, tone_gen_clock_select);
		// level zero action, attenuate or shut down
		brownout_level0_reached <= 1'b1;
		wr(`GLB_IDX_BOPA, 8'h01);
		settle();
		check("l0 atten", 32'h1, brownout_level0_attenuate);
		check("l0 shdn", 32'h0, brownout_level0_shutdown);
		wr(`GLB_IDX_BOPA, 8'h03);
		settle();
		check("l0 atten", 32'h0, brownout_level0_attenuate);
		check("l0 shdn", 32'h1, brownout_level0_shutdown);
		wr(`GLB_IDX_BOPA, 8'h02);
		settle();
		check("l0 shdn", 32'h0, brownout_level0_shutdown);
		brownout_level0_reached <= 1'b0;
		// sum, larger of two, and the cap
		limiter_atten <= 7'h0a;
		brownout_atten <= 7'h14;
		wr(`GLB_IDX_LIMA, 8'h01);
		wr(`GLB_IDX_BOPA, 8'h01);
		wr(`GLB_IDX_BOPB, 8'h2e);
		settle();
		check("combined", 32'h1e, combined_atten);
		wr(`GLB_IDX_DIAG, 8'h20);
		settle();
		check("combined", 32'h14, combined_atten);
		wr(`GLB_IDX_DIAG, 8'h00);
		wr(`GLB_IDX_BOPB, 8'h19);
		settle();
		check("combined", 32'h19, combined_atten);
		// release bit pulses once, never sticks, zero does nothing
		p0 = pulses;
		wr(`GLB_IDX_BOPB, 8'hae);
		settle();
		check("release pulses", 32'h1, pulses - p0);
		rdc(`GLB_IDX_BOPB, 8'h2e);
		wr(`GLB_IDX_BOPB, 8'h2e);
		settle();
		check("release pulses", 32'h1, pulses - p0);
		// unmapped and misaligned accesses are refused
		xfer(1'b0, 10'h060, 8'h00);
		check("unmapped err", 32'h1, {31'h0, er});
		check("unmapped data", 32'h0, rd);
		xfer(1'b1, 10'h069, 8'h55);
		check("misaligned err", 32'h1, {31'h0, er});
		xfer(1'b1, 10'h080, 8'h55);
		check("unmapped err", 32'h1, {31'h0, er});
		rdc(`GLB_IDX_VOL, 8'h01);
		complete_run();
	end

	// hang guard, far beyond the few hundred cycles the tests take
	initial begin
		#100000;
		failures++;
		complete_run();
	end
endmodule
`default_nettype wire
